/* logic/irdc_pkg.sv */
// constants for the isa resource decode and configuration block
package irdc_pkg;
  localparam logic [7:0] OFS_BOOT_MATCH_HI = 8'h40;
  localparam logic [7:0] OFS_BOOT_MATCH_LO = 8'h41;
  localparam logic [7:0] OFS_BOOT_WIDTH = 8'h42;
  localparam logic [7:0] OFS_BOOT_SIZE_HI = 8'h43;
  localparam logic [7:0] OFS_BOOT_SIZE_LO = 8'h44;
  localparam logic [7:0] OFS_SMEM_MATCH_HI = 8'h48;
  localparam logic [7:0] OFS_SMEM_MATCH_LO = 8'h49;
  localparam logic [7:0] OFS_SMEM_WIDTH = 8'h4a;
  localparam logic [7:0] OFS_SMEM_SIZE_HI = 8'h4b;
  localparam logic [7:0] OFS_SMEM_SIZE_LO = 8'h4c;
  localparam logic [7:0] OFS_IO_MATCH_HI = 8'h60;
  localparam logic [7:0] OFS_IO_MATCH_LO = 8'h61;
  localparam logic [7:0] OFS_VENDOR = 8'hf0;
  // vendor byte bit positions
  localparam int VB_IO_WIDE = 0;
  localparam int VB_EXT_IO = 1;
  localparam int VB_PAR_PROM = 2;
  localparam int VB_BOOT_EXT = 3;
  localparam int VB_FLASH = 4;
  localparam int VB_XCVR_POL = 5;
  localparam int VB_LEGACY = 6;
  localparam int WIDTH_BIT = 1;
  localparam int HI_FIELD_POS = 5;
  localparam logic [7:0] VENDOR_RST = 8'h00;
  localparam logic [7:0] WIDTH_RST = 8'h00;
  localparam logic [3:0] SIZE_RST = 4'h0;
  localparam logic [3:0] MATCH_RST = 4'h0;
  localparam logic [4:0] SMEM_MATCH_RST = 5'h00;
  // fixed bits returned in the high halves of split fields
  localparam logic [7:0] BOOT_HI_FIX = 8'h0c;
  localparam logic [7:0] SMEM_HI_FIX = 8'h0c;
  localparam logic [7:0] SIZE_HI_FIX = 8'hfe;
  localparam logic [7:0] IO_HI_FIX = 8'h02;
  // size encodings
  localparam logic [3:0] SZ_8K = 4'hf;
  localparam logic [3:0] SZ_16K = 4'he;
  localparam logic [3:0] SZ_32K = 4'hc;
  localparam logic [3:0] SZ_64K = 4'h8;
  localparam logic [7:0] KEY_STD = 8'h6a;
  localparam logic [7:0] KEY_ALT_DEF = 8'h6b;
  localparam logic [7:0] CSUM_GOOD = 8'hff;
  localparam logic [4:0] LAST_WORD = 5'h1b;
  localparam logic [4:0] VENDOR_WORD = 5'h1a;
  localparam logic [1:0] ADDR_WORDS = 2'h3;
  localparam logic [3:0] EE_DIV = 4'h7;
  typedef enum logic [1:0] {
    IRDC_IDLE = 2'b00,
    IRDC_LOAD = 2'b01,
    IRDC_GOOD = 2'b11,
    IRDC_BAD = 2'b10
  } irdc_state_e;
endpackage : irdc_pkg

/* logic/irdc_top.sv */
// isa resource decode, vendor options and eeprom load with checksum
`timescale 1ns/1ns
module irdc_top
  import irdc_pkg::*;
#(
  parameter logic [7:0] ALT_KEY = KEY_ALT_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgWrEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  input wire logic keyValid,
  input wire logic [7:0] keyByte,
  output logic keyAccept,
  output logic relocMode,
  input wire logic busMasterMode,
  input wire logic sharedMemMode,
  input wire logic tpActive,
  input wire logic sleepMode,
  input wire logic [19:0] saBus,
  input wire logic memRdN,
  input wire logic baleIn,
  input wire logic aenIn,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic eeDataIn,
  input wire logic eeShiftBusyIn,
  output logic eeClk,
  output logic eeShiftBusyOut,
  output logic eeShiftBusyOe,
  output logic [7:0] stationData,
  output logic stationPromSelN,
  output logic bootSelectOutN,
  output logic irq12Out,
  output logic memCs16N,
  output logic ioCs16N,
  output logic ioSelect,
  output logic xcvrEnableOut
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] s0, s1, s2, s3, s4, s5, s6, s7, s8;
  logic [19:0] saM, saS;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0 <= '0; s1 <= '1; s2 <= '0; s3 <= '1; s4 <= '0;
      s5 <= '1; s6 <= '1; s7 <= '0; s8 <= '0;
      saM <= '0; saS <= '0;
    end else begin
      s0 <= {s0[0], eeDataIn};
      s1 <= {s1[0], memRdN};
      s2 <= {s2[0], baleIn};
      s3 <= {s3[0], aenIn};
      s4 <= {s4[0], eeShiftBusyIn};
      s5 <= {s5[0], ioRdN};
      s6 <= {s6[0], ioWrN};
      s7 <= {s7[0], tpActive};
      s8 <= {s8[0], sleepMode};
      saM <= saBus;
      saS <= saM;
    end
  end
  wire eeD = s0[1];
  wire memRd = ~s1[1];
  wire bale = s2[1];
  wire aen = s3[1];
  wire shfPin = s4[1];
  wire ioRd = ~s5[1];
  wire tpS = s7[1];
  wire slpS = s8[1];

  // ==========================================================
  // configuration registers
  logic [3:0] bootMatch_q, bootSize_q, smemSize_q, ioMatch_q;
  logic [4:0] smemMatch_q;
  logic bootWide_q, smemWide_q;
  logic [7:0] vendor_q;
  logic eeWr;
  logic [4:0] eeWordIdx;
  logic [15:0] eeWord;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bootMatch_q <= MATCH_RST;
      bootSize_q <= SIZE_RST;
      smemSize_q <= SIZE_RST;
      ioMatch_q <= MATCH_RST;
      smemMatch_q <= SMEM_MATCH_RST;
      bootWide_q <= 1'b0;
      smemWide_q <= 1'b0;
      vendor_q <= VENDOR_RST;
    end else if (eeWr && eeWordIdx == VENDOR_WORD) begin
      vendor_q <= eeWord[7:0];
    end else if (cfgWrEn) begin
      case (cfgAddr)
        OFS_BOOT_MATCH_HI: bootMatch_q[3] <= cfgWrData[0];
        OFS_BOOT_MATCH_LO: bootMatch_q[2:0] <= cfgWrData[7:5];
        OFS_BOOT_WIDTH: bootWide_q <= cfgWrData[WIDTH_BIT];
        OFS_BOOT_SIZE_HI: bootSize_q[3] <= cfgWrData[0];
        OFS_BOOT_SIZE_LO: bootSize_q[2:0] <= cfgWrData[7:5];
        OFS_SMEM_MATCH_HI: smemMatch_q[4:3] <= cfgWrData[1:0];
        OFS_SMEM_MATCH_LO: smemMatch_q[2:0] <= cfgWrData[7:5];
        OFS_SMEM_WIDTH: smemWide_q <= cfgWrData[WIDTH_BIT];
        OFS_SMEM_SIZE_HI: smemSize_q[3] <= cfgWrData[0];
        OFS_SMEM_SIZE_LO: smemSize_q[2:0] <= cfgWrData[7:5];
        OFS_IO_MATCH_HI: ioMatch_q[3] <= cfgWrData[0];
        OFS_IO_MATCH_LO: ioMatch_q[2:0] <= cfgWrData[7:5];
        OFS_VENDOR: vendor_q <= cfgWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfgRdData <= '0;
    else begin
      case (cfgAddr)
        OFS_BOOT_MATCH_HI: cfgRdData <= BOOT_HI_FIX | {7'h00, bootMatch_q[3]};
        OFS_BOOT_MATCH_LO: cfgRdData <= {bootMatch_q[2:0], 5'h00};
        OFS_BOOT_WIDTH: cfgRdData <= {6'h00, bootWide_q, 1'b0};
        OFS_BOOT_SIZE_HI: cfgRdData <= SIZE_HI_FIX | {7'h00, bootSize_q[3]};
        OFS_BOOT_SIZE_LO: cfgRdData <= {bootSize_q[2:0], 5'h00};
        OFS_SMEM_MATCH_HI:
          cfgRdData <= SMEM_HI_FIX | {6'h00, smemMatch_q[4:3]};
        OFS_SMEM_MATCH_LO: cfgRdData <= {smemMatch_q[2:0], 5'h00};
        OFS_SMEM_WIDTH: cfgRdData <= {6'h00, smemWide_q, 1'b0};
        OFS_SMEM_SIZE_HI: cfgRdData <= SIZE_HI_FIX | {7'h00, smemSize_q[3]};
        OFS_SMEM_SIZE_LO: cfgRdData <= {smemSize_q[2:0], 5'h00};
        OFS_IO_MATCH_HI: cfgRdData <= IO_HI_FIX | {7'h00, ioMatch_q[3]};
        OFS_IO_MATCH_LO: cfgRdData <= {ioMatch_q[2:0], 5'h00};
        OFS_VENDOR: cfgRdData <= {1'b0, vendor_q[6:0]};
        default: cfgRdData <= '0;
      endcase
    end
  end

  // ==========================================================
  // memory decode
  function automatic logic [3:0] size_mask(input logic [3:0] sz);
    logic [3:0] m;
    m = 4'h0;
    case (sz)
      SZ_8K: m = 4'hf;
      SZ_16K: m = 4'he;
      SZ_32K: m = 4'hc;
      SZ_64K: m = 4'h8;
      default: m = 4'h0;
    endcase
    return m;
  endfunction : size_mask
  function automatic logic size_ok(input logic [3:0] sz);
    return sz[3] && (sz == SZ_8K || sz == SZ_16K || sz == SZ_32K ||
      sz == SZ_64K);
  endfunction : size_ok

  wire [3:0] bMask = size_mask(bootSize_q);
  wire bootSized = size_ok(bootSize_q);
  wire [3:0] bCmp = vendor_q[VB_BOOT_EXT] ?
    {1'b0, bootMatch_q[2:0] ^ saS[15:13]} :
    bootMatch_q ^ saS[16:13];
  // external select: BALE low stands in for bits above 15
  wire bootHigh = vendor_q[VB_BOOT_EXT] ? ~bale :
    (saS[19:17] == 3'b110);
  wire bootHit = memRd && bootSized && bootHigh &&
    ((bCmp & bMask) == 4'h0);

  wire smemActive = sharedMemMode && !busMasterMode;
  wire [3:0] sMask = size_mask(smemSize_q);
  wire [2:0] sCmp = smemMatch_q[2:0] ^ saS[15:13];
  wire smemHit = smemActive && size_ok(smemSize_q) &&
    (saS[19:18] == 2'b11) && (smemMatch_q[4:3] == saS[17:16]) &&
    ((sCmp & sMask[2:0]) == 3'h0);

  // ==========================================================
  // io decode
  wire ioBase = vendor_q[VB_EXT_IO] ? ~aen :
    (!aen && saS[9] && (saS[8:5] == ioMatch_q));
  wire stationSpace = ioBase && (saS[4] == 1'b0);

  // ==========================================================
  // eeprom load
  irdc_state_e state_q;
  logic [3:0] div_q;
  logic [3:0] bit_q;
  logic [15:0] shift_q;
  logic [7:0] sum_q;
  logic loadGood_q;
  logic [7:0] station_q [6];
  wire tick = (div_q == EE_DIV);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_q <= '0;
    else div_q <= tick ? 4'h0 : 4'(div_q + 4'h1);
  end
  assign eeWr = tick && state_q == IRDC_LOAD && bit_q == 4'hf;
  assign eeWord = {shift_q[14:0], eeD};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= IRDC_IDLE;
      bit_q <= '0;
      eeWordIdx <= '0;
      shift_q <= '0;
      sum_q <= '0;
      loadGood_q <= 1'b0;
    end else begin
      case (state_q)
        IRDC_IDLE: if (tick) state_q <= shfPin ? IRDC_LOAD : IRDC_BAD;
        IRDC_LOAD: if (tick) begin
          shift_q <= eeWord;
          bit_q <= 4'(bit_q + 4'h1);
          if (bit_q == 4'hf) begin
            sum_q <= 8'(sum_q + eeWord[7:0] + eeWord[15:8]);
            eeWordIdx <= 5'(eeWordIdx + 5'h1);
            if (eeWordIdx == LAST_WORD) begin
              if (8'(sum_q + eeWord[7:0] + eeWord[15:8]) == CSUM_GOOD) begin
                state_q <= IRDC_GOOD;
                loadGood_q <= 1'b1;
              end else state_q <= IRDC_BAD;
            end
          end
        end
        IRDC_GOOD: ;
        IRDC_BAD: ;
        default: state_q <= IRDC_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (eeWr && eeWordIdx < {3'h0, ADDR_WORDS}) begin
      station_q[{eeWordIdx[1:0], 1'b0}] <= eeWord[7:0];
      station_q[{eeWordIdx[1:0], 1'b1}] <= eeWord[15:8];
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eeClk <= 1'b0;
      eeShiftBusyOut <= 1'b1;
      // pin released so a fitted memory's pull-up can be sensed
      eeShiftBusyOe <= 1'b0;
      relocMode <= 1'b0;
      keyAccept <= 1'b0;
      stationData <= '0;
      stationPromSelN <= 1'b1;
      bootSelectOutN <= 1'b1;
      irq12Out <= 1'b1;
      memCs16N <= 1'b1;
      ioCs16N <= 1'b1;
      ioSelect <= 1'b0;
      xcvrEnableOut <= 1'b1;
    end else begin
      eeClk <= (state_q == IRDC_LOAD) && div_q[3 - 1];
      eeShiftBusyOut <= (state_q != IRDC_GOOD);
      // driven only once the pin level has been sampled
      eeShiftBusyOe <= (state_q != IRDC_IDLE);
      relocMode <= (state_q == IRDC_BAD);
      if (vendor_q[VB_LEGACY])
        keyAccept <= keyValid && keyByte == ALT_KEY;
      else
        keyAccept <= keyValid &&
          (keyByte == (loadGood_q ? KEY_STD : ALT_KEY));
      stationPromSelN <=
        ~(vendor_q[VB_PAR_PROM] && stationSpace && ioRd);
      stationData <= vendor_q[VB_PAR_PROM] ? 8'h00 :
        station_q[3'(saS[2:0] % 6)];
      ioSelect <= ioBase && (ioRd || !s6[1]);
      ioCs16N <= ~(ioBase && vendor_q[VB_IO_WIDE]);
      memCs16N <= ~((bootHit && bootWide_q && !busMasterMode) ||
        (smemHit && smemWide_q));
      if (vendor_q[VB_FLASH] && busMasterMode) begin
        bootSelectOutN <= ~(bootHit && memRd);
        irq12Out <= ~(bootHit && !s6[1]);
      end else if (vendor_q[VB_FLASH] && smemActive) begin
        bootSelectOutN <= ~bootHit;
        irq12Out <= ~smemHit;
      end else begin
        bootSelectOutN <= ~bootHit;
        irq12Out <= 1'b1;
      end
      xcvrEnableOut <= ((tpS || slpS) ^ vendor_q[VB_XCVR_POL]);
    end
  end

  // ==========================================================
  // checks
  legacy_key_a: assert property (@(posedge clk) disable iff (rst)
    vendor_q[VB_LEGACY] && keyValid && keyByte == KEY_STD
    && ALT_KEY != KEY_STD |=> !keyAccept)
    else $error("standard key accepted in legacy mode");
  busy_bad_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IRDC_BAD |=> eeShiftBusyOut)
    else $error("shift busy low after bad sum");
  busy_good_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IRDC_GOOD |=> !eeShiftBusyOut)
    else $error("shift busy high after good sum");
  master_narrow_a: assert property (@(posedge clk) disable iff (rst)
    busMasterMode && $stable(busMasterMode) && !smemHit |=> memCs16N)
    else $error("wide boot cycle in master mode");
  io_wide_a: assert property (@(posedge clk) disable iff (rst)
    !vendor_q[VB_IO_WIDE] && $stable(vendor_q) |=> ioCs16N)
    else $error("io 16 select without width bit");
  xcvr_pol_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> xcvrEnableOut == (($past(tpS) || $past(slpS)) ^
    $past(vendor_q[VB_XCVR_POL])))
    else $error("transceiver enable wrong polarity");
  no_size_a: assert property (@(posedge clk) disable iff (rst)
    !bootSize_q[3] |-> !bootHit)
    else $error("boot hit with no prom size");
  smem_off_a: assert property (@(posedge clk) disable iff (rst)
    busMasterMode |-> !smemHit)
    else $error("shared memory hit in master mode");
  busy_sense_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IRDC_IDLE |=> !eeShiftBusyOe)
    else $error("shift busy driven while sensing the pin");
  reloc_bad_a: assert property (@(posedge clk) disable iff (rst)
    state_q == IRDC_BAD |=> relocMode)
    else $error("relocatable mode missing after failed load");
  boot_ext_a: assert property (@(posedge clk) disable iff (rst)
    vendor_q[VB_BOOT_EXT] && bale |=> bootSelectOutN)
    else $error("boot select with external select high");
  io_ext_a: assert property (@(posedge clk) disable iff (rst)
    vendor_q[VB_EXT_IO] && aen |=> !ioSelect)
    else $error("io select with external select high");
  flash_ram_a: assert property (@(posedge clk) disable iff (rst)
    vendor_q[VB_FLASH] && smemActive |=> irq12Out == !$past(smemHit))
    else $error("static ram select wrong with flash in shared mode");
  good_cv: cover property (@(posedge clk) state_q == IRDC_GOOD);
  bad_cv: cover property (@(posedge clk) state_q == IRDC_BAD);
  boot_cv: cover property (@(posedge clk) bootHit);
  flash_cv: cover property (@(posedge clk) vendor_q[VB_FLASH] && !irq12Out);
endmodule : irdc_top

/* tb/irdc_eeprom_model.sv */
// serial configuration eeprom and shift-busy pin seen by the block
`timescale 1ns/1ns
module irdc_eeprom_model (
  input wire logic rst,
  input wire logic eeClk,
  input wire logic busyOut,
  input wire logic busyOe,
  input wire logic corrupt,
  input wire logic absent,
  output logic dataOut,
  output logic busyPin
);
  int bitIdx;
  logic [15:0] cur;
  function automatic logic [15:0] wordAt(input int w);
    case (w)
      0: return 16'h5a5a;
      1: return 16'hc3c3;
      2: return 16'h9696;
      26: return 16'h0001;
      // last word balances the byte sum to ff unless corrupted
      27: return corrupt ? 16'h0099 : 16'h0098;
      default: return 16'h0000;
    endcase
  endfunction : wordAt
  always @(posedge rst or negedge eeClk) begin
    if (rst) begin
      bitIdx <= 0;
    end else begin
      bitIdx <= bitIdx + 1;
    end
  end
  // msb first, sixteen bits per word
  always_comb begin
    cur = wordAt(bitIdx / 16);
    if (absent) begin
      dataOut = ~bitIdx[0];
    end else begin
      dataOut = cur[15 - bitIdx % 16];
    end
  end
  // pulled up only while a memory is fitted
  always_comb begin
    busyPin = busyOe ? busyOut : ~absent;
  end
endmodule : irdc_eeprom_model

/* tb/testbench.sv */
// self-checking bench for the isa resource decode block
`timescale 1ns/1ns
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin \
  badCount++; $display("CHECK FAILED at %0t: got %0h expected %0h", \
  $time, got, exp); end end
module testbench;
  import irdc_pkg::*;
  logic clk, rst, cfgWrEn, keyValid, busMasterMode, sharedMemMode;
  logic tpActive, sleepMode, memRdN, baleIn, aenIn, ioRdN, ioWrN;
  logic corrupt, absent, keyAccept, relocMode, eeClk, eeShiftBusyOut;
  logic eeShiftBusyOe, stationPromSelN, bootSelectOutN, irq12Out;
  logic memCs16N, ioCs16N, ioSelect, xcvrEnableOut, eeData, eeBusyPin;
  logic [7:0] cfgAddr, cfgWrData, keyByte, cfgRdData, stationData;
  logic [19:0] saBus;
  logic [7:0] regA [11] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h48,
    8'h49, 8'h4a, 8'h4b, 8'h4c, 8'hf0};
  logic [7:0] regM [11] = '{8'h01, 8'he0, 8'h02, 8'h01, 8'he0, 8'h03,
    8'he0, 8'h02, 8'h01, 8'he0, 8'h7f};
  logic [7:0] regF [11] = '{8'h0c, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h0c,
    8'h00, 8'h00, 8'hfe, 8'h00, 8'h00};
  logic [7:0] stn [3] = '{8'h5a, 8'hc3, 8'h96};
  int badCount = 0;
  int checkCount = 0;
  int cycles = 0;
  irdc_top irdc_top_i (.clk(clk), .rst(rst), .cfgWrEn(cfgWrEn),
    .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .keyValid(keyValid), .keyByte(keyByte), .keyAccept(keyAccept),
    .relocMode(relocMode), .busMasterMode(busMasterMode),
    .sharedMemMode(sharedMemMode), .tpActive(tpActive),
    .sleepMode(sleepMode), .saBus(saBus), .memRdN(memRdN),
    .baleIn(baleIn), .aenIn(aenIn), .ioRdN(ioRdN), .ioWrN(ioWrN),
    .eeDataIn(eeData), .eeShiftBusyIn(eeBusyPin), .eeClk(eeClk),
    .eeShiftBusyOut(eeShiftBusyOut), .eeShiftBusyOe(eeShiftBusyOe),
    .stationData(stationData), .stationPromSelN(stationPromSelN),
    .bootSelectOutN(bootSelectOutN), .irq12Out(irq12Out),
    .memCs16N(memCs16N), .ioCs16N(ioCs16N), .ioSelect(ioSelect),
    .xcvrEnableOut(xcvrEnableOut));
  irdc_eeprom_model irdc_eeprom_model_i (.rst(rst), .eeClk(eeClk),
    .busyOut(eeShiftBusyOut), .busyOe(eeShiftBusyOe), .corrupt(corrupt),
    .absent(absent), .dataOut(eeData), .busyPin(eeBusyPin));
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tallyAndFinish
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfgWrEn = 1'b1;
    cfgAddr = a;
    cfgWrData = d;
    @(negedge clk);
    cfgWrEn = 1'b0;
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    cfgAddr = a;
    @(negedge clk);
    `CHK(cfgRdData, e)
  endtask : rdChk
  // accept may land one or two edges after the key byte
  task automatic keyChk(input logic [7:0] k, input logic e);
    logic seen;
    @(negedge clk);
    keyValid = 1'b1;
    keyByte = k;
    @(negedge clk);
    keyValid = 1'b0;
    seen = keyAccept;
    @(negedge clk);
    seen = seen | keyAccept;
    `CHK(seen, e)
  endtask : keyChk
  // pins pass two sync stages and one output stage
  task automatic pins(input logic [19:0] a, input logic mr, input logic ir);
    @(negedge clk);
    saBus = a;
    memRdN = mr;
    ioRdN = ir;
    repeat (5) @(negedge clk);
  endtask : pins
  task automatic doReset(input logic c, input logic ab);
    @(negedge clk);
    corrupt = c;
    absent = ab;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask : doReset
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      badCount++;
      tallyAndFinish();
    end
  end
  initial begin
    {cfgWrEn, keyValid, busMasterMode, sharedMemMode} = 4'h0;
    {tpActive, sleepMode, aenIn, corrupt, absent} = 5'h00;
    {memRdN, baleIn, ioRdN, ioWrN, rst} = 5'h1f;
    {cfgAddr, cfgWrData, keyByte} = 24'h00_0000;
    saBus = 20'h0_0000;
    repeat (5) @(negedge clk);
    `CHK(eeShiftBusyOut, 1'b1)
    `CHK(bootSelectOutN, 1'b1)
    `CHK(eeShiftBusyOe, 1'b0)
    rst = 1'b0;
    for (int i = 0; i < 6000 && eeShiftBusyOut !== 1'b0; i++) begin
      @(negedge clk);
    end
    `CHK(eeShiftBusyOut, 1'b0)
    `CHK(relocMode, 1'b0)
    `CHK(eeShiftBusyOe, 1'b1)
    rdChk(OFS_VENDOR, 8'h01);
    for (int i = 0; i < 6; i++) begin
      pins(20'h0_0000 | i, 1'b1, 1'b1);
      `CHK(stationData, stn[i / 2])
    end
    wr(OFS_IO_MATCH_HI, 8'h02);
    wr(OFS_IO_MATCH_LO, 8'h60);
    pins(20'h0_0264, 1'b1, 1'b0);
    `CHK(ioSelect, 1'b1)
    `CHK(ioCs16N, 1'b0)
    pins(20'h0_0284, 1'b1, 1'b0);
    `CHK(ioSelect, 1'b0)
    wr(OFS_VENDOR, 8'h00);
    pins(20'h0_0264, 1'b1, 1'b0);
    `CHK(ioCs16N, 1'b1)
    wr(OFS_VENDOR, 8'h02);
    pins(20'h0_0104, 1'b1, 1'b0);
    `CHK(ioSelect, 1'b1)
    wr(OFS_VENDOR, 8'h04);
    pins(20'h0_0260, 1'b1, 1'b0);
    `CHK(stationPromSelN, 1'b0)
    `CHK(stationData, 8'h00)
    wr(OFS_VENDOR, 8'h00);
    keyChk(KEY_STD, 1'b1);
    keyChk(KEY_ALT_DEF, 1'b0);
    wr(OFS_VENDOR, 8'h40);
    keyChk(KEY_STD, 1'b0);
    keyChk(KEY_ALT_DEF, 1'b1);
    for (int w = 0; w < 2; w++) begin
      for (int r = 0; r < 11; r++) begin
        wr(regA[r], w ? 8'h00 : 8'hff);
        rdChk(regA[r], (w ? 8'h00 : regM[r]) | regF[r]);
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFS_VENDOR, i[1] ? 8'h20 : 8'h00);
      tpActive = i[0];
      sleepMode = ~i[0];
      pins(20'h0_0000, 1'b1, 1'b1);
      `CHK(xcvrEnableOut, 1'b1 ^ i[1])
    end
    tpActive = 1'b0;
    sleepMode = 1'b0;
    pins(20'h0_0000, 1'b1, 1'b1);
    `CHK(xcvrEnableOut, 1'b1)
    wr(OFS_VENDOR, 8'h00);
    pins(20'h0_0000, 1'b1, 1'b1);
    `CHK(xcvrEnableOut, 1'b0)
    wr(OFS_BOOT_MATCH_HI, 8'h00);
    wr(OFS_BOOT_MATCH_LO, 8'h80);
    wr(OFS_BOOT_SIZE_HI, 8'h01);
    wr(OFS_BOOT_SIZE_LO, 8'he0);
    wr(OFS_BOOT_WIDTH, 8'h02);
    pins(20'hc_8000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b0)
    `CHK(memCs16N, 1'b0)
    busMasterMode = 1'b1;
    pins(20'hc_8000, 1'b0, 1'b1);
    `CHK(memCs16N, 1'b1)
    busMasterMode = 1'b0;
    pins(20'hc_a000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b1)
    pins(20'hd_8000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b1)
    wr(OFS_BOOT_SIZE_LO, 8'hc0);
    pins(20'hc_a000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b0)
    wr(OFS_VENDOR, 8'h08);
    baleIn = 1'b0;
    pins(20'h0_a000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b0)
    baleIn = 1'b1;
    pins(20'h0_a000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b1)
    wr(OFS_VENDOR, 8'h10);
    busMasterMode = 1'b1;
    ioWrN = 1'b0;
    pins(20'hc_a000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b0)
    `CHK(irq12Out, 1'b0)
    ioWrN = 1'b1;
    busMasterMode = 1'b0;
    wr(OFS_VENDOR, 8'h00);
    wr(OFS_BOOT_SIZE_HI, 8'h00);
    pins(20'hc_8000, 1'b0, 1'b1);
    `CHK(bootSelectOutN, 1'b1)
    sharedMemMode = 1'b1;
    wr(OFS_SMEM_MATCH_HI, 8'h0d);
    wr(OFS_SMEM_MATCH_LO, 8'h20);
    wr(OFS_SMEM_SIZE_HI, 8'h01);
    wr(OFS_SMEM_SIZE_LO, 8'he0);
    wr(OFS_SMEM_WIDTH, 8'h02);
    pins(20'hd_2000, 1'b0, 1'b1);
    `CHK(memCs16N, 1'b0)
    wr(OFS_VENDOR, 8'h10);
    pins(20'hd_2000, 1'b0, 1'b1);
    `CHK(irq12Out, 1'b0)
    busMasterMode = 1'b1;
    pins(20'hd_2000, 1'b0, 1'b1);
    `CHK(memCs16N, 1'b1)
    {busMasterMode, sharedMemMode} = 2'b00;
    doReset(1'b1, 1'b0);
    for (int i = 0; i < 6000 && relocMode !== 1'b1; i++) begin
      @(negedge clk);
    end
    `CHK(relocMode, 1'b1)
    `CHK(eeShiftBusyOut, 1'b1)
    keyChk(KEY_STD, 1'b0);
    keyChk(KEY_ALT_DEF, 1'b1);
    doReset(1'b0, 1'b1);
    for (int i = 0; i < 200 && relocMode !== 1'b1; i++) begin
      @(negedge clk);
    end
    `CHK(relocMode, 1'b1)
    rdChk(OFS_VENDOR, 8'h00);
    keyChk(KEY_ALT_DEF, 1'b1);
    tallyAndFinish();
  end
endmodule : testbench
